// ==== verilog/htwrp_device.sv ====
`timescale 1ns/1ns
`include "htwrp_defs.svh"
// Operation
// - Bytes travel most significant bit first
// - Strap levels latched at reset release
// - Upper five address bits fixed, two strapped
// - Reset held low 50 ms at power-up
// - Direction bit selects transmit or receive
// - First written byte loads the pointer
// - Pointer increments after each register byte
// - Host leaves reserved registers at defaults
// - STOP after own address clears pointer
// - Foreign address ignored until next START
// - START keeps the pointer unchanged
// - Later write continues at current pointer
// - Host ends every message with STOP
// - Read after STOP starts at location 00
// - General port selectable as tuner bus
// - Scan control bit three enables master mode
module htwrp_device (
   input wire logic CORE_CLK_I,
   input wire logic NRST_I,
   input wire logic [1:0] BUS_ADDRESS_STRAP_I,
   input wire logic TUNER_BUS_CLOCK_LOW_I,
   input wire logic TUNER_BUS_DATA_LOW_I,
   input wire logic GENERAL_PORT_BIT_ZERO_I,
   output logic GENERAL_PORT_BIT_ZERO_O,
   output logic GENERAL_PORT_BIT_ZERO_OE_O,
   input wire logic GENERAL_PORT_BIT_ONE_I,
   output logic GENERAL_PORT_BIT_ONE_O,
   output logic GENERAL_PORT_BIT_ONE_OE_O,
   output logic REG_WRITE_O,
   output htwrp_pkg::htwrp_byte_t REG_WRITE_ADDR_O,
   output htwrp_pkg::htwrp_byte_t REG_WRITE_DATA_O,
   htwrp_if.dev HBUS
);
   import htwrp_pkg::*;
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic scl_d_reg;
   logic sda_d_reg;
   logic [1:0] strap_s1_reg;
   logic [1:0] strap_s2_reg;
   logic [1:0] strap_cnt_reg;
   logic [1:0] own_addr_reg;
   logic addr_ok_reg;
   htwrp_dev_state_e state_reg, state_next;
   logic [2:0] cnt_reg, cnt_next;
   htwrp_byte_t shift_reg, shift_next;
   htwrp_byte_t ptr_reg, ptr_next;
   logic expect_reg, expect_next;
   logic addressed_reg, addressed_next;
   logic rw_reg, rw_next;
   logic sda_oe_reg, sda_oe_next;
   logic wr_reg, wr_next;
   htwrp_byte_t wr_addr_reg;
   htwrp_byte_t wr_data_reg;
   htwrp_byte_t mem [0:255];
   logic [1:0] gp_s1_reg;
   logic [1:0] gp_s2_reg;
   logic [1:0] gp_oe_reg;
   logic [1:0] gp_out_reg;
   logic [1:0] gp_oe_next;
   logic [1:0] gp_out_next;
   // -----------------------------------------
   // Bus conditions
   // -----------------------------------------
   wire scl_s = scl_sync_reg[1];
   wire sda_s = sda_sync_reg[1];
   wire scl_rise = scl_s & !scl_d_reg;
   wire scl_fall = !scl_s & scl_d_reg;
   wire start_cond = scl_s & scl_d_reg & sda_d_reg & !sda_s;
   wire stop_cond = scl_s & scl_d_reg & !sda_d_reg & sda_s;
   wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
   wire last_bit = (cnt_reg == `HTW_LAST_BIT);
   wire addr_hit = addr_ok_reg &&
      (rx_byte[7:1] == {`HTW_FIXED_ADDR, own_addr_reg});
   wire [7:0] ptr_inc = ptr_reg + 8'h01;
   wire [7:0] scan = mem[`HTW_SCAN_OFS];
   wire [7:0] gpc = mem[`HTW_GPC_OFS];
   wire gpin_sel = (ptr_reg == `HTW_GPIN_OFS);
   wire [7:0] rd_byte = gpin_sel ? {6'h00, gp_s2_reg} : mem[ptr_reg];
   wire [1:0] tuner_low = {TUNER_BUS_DATA_LOW_I, TUNER_BUS_CLOCK_LOW_I};
   wire [1:0] gp_in = {GENERAL_PORT_BIT_ONE_I, GENERAL_PORT_BIT_ZERO_I};
   wire tuner_en = gpc[`HTW_TUNER_EN_BIT];
   wire master = scan[`HTW_MASTER_BIT];
   // -----------------------------------------
   // Synchronisers and strap capture
   // -----------------------------------------
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         gp_s1_reg <= 2'h0;
         gp_s2_reg <= 2'h0;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], HBUS.scl};
         sda_sync_reg <= {sda_sync_reg[0], HBUS.sda};
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
         gp_s1_reg <= gp_in;
         gp_s2_reg <= gp_s1_reg;
      end
   end
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         strap_s1_reg <= 2'h0;
         strap_s2_reg <= 2'h0;
         strap_cnt_reg <= 2'h0;
         own_addr_reg <= 2'h0;
         addr_ok_reg <= 1'b0;
      end else begin
         strap_s1_reg <= BUS_ADDRESS_STRAP_I;
         strap_s2_reg <= strap_s1_reg;
         if (!addr_ok_reg) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
         end
         if (!addr_ok_reg && strap_cnt_reg == `HTW_STRAP_WAIT) begin
            own_addr_reg <= strap_s2_reg;
            addr_ok_reg <= 1'b1;
         end
      end
   end
   // -----------------------------------------
   // Slave state machine
   // -----------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      ptr_next = ptr_reg;
      expect_next = expect_reg;
      addressed_next = addressed_reg;
      rw_next = rw_reg;
      sda_oe_next = sda_oe_reg;
      wr_next = 1'b0;
      if (stop_cond) begin
         state_next = DS_IDLE;
         sda_oe_next = 1'b0;
         expect_next = 1'b1;
         addressed_next = 1'b0;
         if (addressed_reg) begin
            ptr_next = `HTW_PTR_RST;
         end
      end else if (start_cond) begin
         state_next = DS_ADDR;
         cnt_next = 3'h0;
         sda_oe_next = 1'b0;
      end else if (scl_rise) begin
         case (state_reg)
            DS_ADDR: begin
               shift_next = rx_byte;
               cnt_next = cnt_reg + 3'h1;
               if (last_bit && addr_hit) begin
                  state_next = DS_ACK_PEND;
                  rw_next = sda_s;
                  addressed_next = 1'b1;
                  if (sda_s) begin
                     expect_next = 1'b0;
                  end
               end else if (last_bit) begin
                  state_next = DS_IGNORE;
               end
            end
            DS_RX: begin
               shift_next = rx_byte;
               cnt_next = cnt_reg + 3'h1;
               if (last_bit) begin
                  state_next = DS_ACK_PEND;
                  if (expect_reg) begin
                     ptr_next = rx_byte;
                     expect_next = 1'b0;
                  end else begin
                     wr_next = !gpin_sel;
                     ptr_next = ptr_inc;
                  end
               end
            end
            DS_TX: begin
               cnt_next = cnt_reg + 3'h1;
               if (last_bit) begin
                  state_next = DS_TX_ACK;
                  ptr_next = ptr_inc;
               end
            end
            DS_TX_ACK: begin
               state_next = sda_s ? DS_IGNORE : DS_TX_NEXT;
            end
            default: begin
               state_next = state_reg;
            end
         endcase
      end else if (scl_fall) begin
         case (state_reg)
            DS_ACK_PEND: begin
               sda_oe_next = 1'b1;
               state_next = DS_ACK_HOLD;
            end
            DS_ACK_HOLD, DS_TX_NEXT: begin
               cnt_next = 3'h0;
               sda_oe_next = 1'b0;
               state_next = DS_RX;
               if (rw_reg) begin
                  shift_next = rd_byte;
                  sda_oe_next = !rd_byte[7];
                  state_next = DS_TX;
               end
            end
            DS_TX: begin
               sda_oe_next = !shift_reg[6];
               shift_next = {shift_reg[6:0], 1'b0};
            end
            DS_TX_ACK: begin
               sda_oe_next = 1'b0;
            end
            default: begin
               sda_oe_next = sda_oe_reg;
            end
         endcase
      end
   end
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_reg <= DS_IDLE;
         cnt_reg <= 3'h0;
         shift_reg <= 8'h00;
         ptr_reg <= `HTW_PTR_RST;
         expect_reg <= 1'b1;
         addressed_reg <= 1'b0;
         rw_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         ptr_reg <= ptr_next;
         expect_reg <= expect_next;
         addressed_reg <= addressed_next;
         rw_reg <= rw_next;
         sda_oe_reg <= sda_oe_next;
      end
   end
   // -----------------------------------------
   // Register locations
   // -----------------------------------------
   // Reset loop keeps every location defined
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         for (int i = 0; i < 256; i++) begin
            mem[i] <= `HTW_REG_RST;
         end
         wr_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         wr_data_reg <= 8'h00;
      end else begin
         wr_reg <= wr_next;
         if (wr_next) begin
            mem[ptr_reg] <= rx_byte;
            wr_addr_reg <= ptr_reg;
            wr_data_reg <= rx_byte;
         end
      end
   end
   // -----------------------------------------
   // General port and tuner bus
   // -----------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_gp
      // Bit zero clock, bit one data
      assign gp_oe_next[g] = tuner_en ? (master & tuner_low[g])
                                      : gpc[`HTW_GP_OE_LSB + g];
      assign gp_out_next[g] = tuner_en ? 1'b0 : gpc[`HTW_GP_OUT_LSB + g];
   end
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         gp_oe_reg <= 2'h0;
         gp_out_reg <= 2'h0;
      end else begin
         gp_oe_reg <= gp_oe_next;
         gp_out_reg <= gp_out_next;
      end
   end
   assign GENERAL_PORT_BIT_ZERO_O = gp_out_reg[0];
   assign GENERAL_PORT_BIT_ZERO_OE_O = gp_oe_reg[0];
   assign GENERAL_PORT_BIT_ONE_O = gp_out_reg[1];
   assign GENERAL_PORT_BIT_ONE_OE_O = gp_oe_reg[1];
   assign REG_WRITE_O = wr_reg;
   assign REG_WRITE_ADDR_O = wr_addr_reg;
   assign REG_WRITE_DATA_O = wr_data_reg;
   assign HBUS.dev_sda_out = 1'b0;
   assign HBUS.dev_sda_oe = sda_oe_reg;
endmodule

// ==== verilog/htwrp_defs.svh ====
`ifndef HTWRP_DEFS_SVH
`define HTWRP_DEFS_SVH
`define HTW_FIXED_ADDR 5'h03
`define HTW_REG_RST 8'h00
`define HTW_PTR_RST 8'h00
`define HTW_SCAN_OFS 8'h62
`define HTW_GPC_OFS 8'h8C
`define HTW_GPIN_OFS 8'h8D
`define HTW_MASTER_BIT 3
`define HTW_TUNER_EN_BIT 0
`define HTW_GP_OE_LSB 1
`define HTW_GP_OUT_LSB 5
`define HTW_LAST_BIT 3'h7
`define HTW_STRAP_WAIT 2'h2
`define HTW_CLK_NS 20
`define HTW_SCL_PERIOD_NS 2600
`define HTW_QTR_NS (`HTW_SCL_PERIOD_NS / 4)
`define HTW_QTR_CYC ((`HTW_QTR_NS + `HTW_CLK_NS - 1) / `HTW_CLK_NS)
`define HTW_RST_HOLD_NS 50000000
`define HTW_RST_HOLD_CYC (`HTW_RST_HOLD_NS / `HTW_CLK_NS)
`define HTW_CMD_OFS 4'h0
`define HTW_STAT_OFS 4'h4
`define HTW_RX_OFS 4'h8
`define HTW_OP_LSB 8
`define HTW_NACK_BIT 10
`define HTW_ACK_BIT 4'h8
`endif

// ==== verilog/htwrp_pkg.sv ====
package htwrp_pkg;
   typedef logic [7:0] htwrp_byte_t;
   typedef enum logic [1:0] {
      HTW_OP_START, HTW_OP_STOP, HTW_OP_WRITE, HTW_OP_READ
   } htwrp_op_e;
   typedef enum logic [3:0] {
      DS_IDLE, DS_ADDR, DS_ACK_PEND, DS_ACK_HOLD, DS_RX,
      DS_TX, DS_TX_ACK, DS_TX_NEXT, DS_IGNORE
   } htwrp_dev_state_e;
   typedef enum logic [1:0] {
      HS_IDLE, HS_START, HS_STOP, HS_BYTE
   } htwrp_host_state_e;
endpackage

// ==== verilog/htwrp_if.sv ====
`timescale 1ns/1ns
interface htwrp_if;
   logic host_scl_out;
   logic host_scl_oe;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // -----------------------------------------
   // Wired-and bus with pull-ups
   // -----------------------------------------
   assign scl = !(host_scl_oe & !host_scl_out);
   assign sda = !((host_sda_oe & !host_sda_out) |
                  (dev_sda_oe & !dev_sda_out));
   modport host (
      output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe,
      input scl, sda
   );
   modport dev (
      output dev_sda_out, dev_sda_oe,
      input scl, sda
   );
endinterface

// ==== verilog/htwrp_host.sv ====
`timescale 1ns/1ns
`include "htwrp_defs.svh"
module htwrp_host #(
   parameter int unsigned RESET_HOLD_CYC = `HTW_RST_HOLD_CYC
) (
   input wire logic CORE_CLK_I,
   input wire logic NRST_I,
   input wire logic [3:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   output logic DEV_NRST_O,
   htwrp_if.host HBUS
);
   import htwrp_pkg::*;
   localparam logic [7:0] QTR = 8'(`HTW_QTR_CYC - 1);
   htwrp_host_state_e st_reg, st_next;
   logic [1:0] ph_reg, ph_next;
   logic [7:0] qcnt_reg, qcnt_next;
   logic [3:0] bit_reg, bit_next;
   htwrp_byte_t sh_reg, sh_next;
   htwrp_byte_t rx_reg, rx_next;
   logic rd_reg, rd_next;
   logic nreq_reg, nreq_next;
   logic nack_reg, nack_next;
   logic scl_oe_reg, scl_oe_next;
   logic sda_oe_reg, sda_oe_next;
   logic [1:0] sda_sync_reg;
   logic [31:0] hold_reg;
   logic rst_done_reg;
   logic ack_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   // -----------------------------------------
   // Register slave
   // -----------------------------------------
   wire busy = (st_reg != HS_IDLE) | !rst_done_reg;
   wire cmd_sel = (AVS_ADDRESS_I == `HTW_CMD_OFS);
   wire stall = cmd_sel & AVS_WRITE_I & busy;
   wire ack_next = (AVS_READ_I | AVS_WRITE_I) & !ack_reg & !stall;
   wire cmd_take = AVS_WRITE_I & ack_reg & cmd_sel &
                   (AVS_BYTEENABLE_I[1:0] == 2'h3);
   wire [31:0] stat_word = {29'h0, rst_done_reg, nack_reg, busy};
   wire [31:0] rd_mux =
      (AVS_ADDRESS_I == `HTW_STAT_OFS) ? stat_word :
      (AVS_ADDRESS_I == `HTW_RX_OFS) ? {24'h0, rx_reg} : 32'h0;
   wire [1:0] op_bits = AVS_WRITEDATA_I[`HTW_OP_LSB +: 2];
   wire htwrp_op_e op = htwrp_op_e'(op_bits);
   wire tick = (qcnt_reg == 8'h00);
   wire ack_bit = (bit_reg == `HTW_ACK_BIT);
   wire sda_s = sda_sync_reg[1];
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ack_reg <= 1'b0;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0;
      end else begin
         ack_reg <= ack_next;
         // Own flop so the pin comes straight from a register
         wait_reg <= !ack_next;
         if (ack_next & AVS_READ_I) begin
            rdata_reg <= rd_mux;
         end
      end
   end
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         hold_reg <= 32'h0;
         rst_done_reg <= 1'b0;
         sda_sync_reg <= 2'h3;
      end else begin
         sda_sync_reg <= {sda_sync_reg[0], HBUS.sda};
         if (!rst_done_reg) begin
            hold_reg <= hold_reg + 32'h1;
         end
         if (hold_reg >= 32'(RESET_HOLD_CYC)) begin
            rst_done_reg <= 1'b1;
         end
      end
   end
   // -----------------------------------------
   // Bus sequencer, four quarters a bit
   // -----------------------------------------
   always_comb begin
      st_next = st_reg;
      ph_next = ph_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      rx_next = rx_reg;
      rd_next = rd_reg;
      nreq_next = nreq_reg;
      nack_next = nack_reg;
      scl_oe_next = scl_oe_reg;
      sda_oe_next = sda_oe_reg;
      qcnt_next = tick ? QTR : qcnt_reg - 8'h01;
      if (st_reg == HS_IDLE) begin
         qcnt_next = QTR;
         ph_next = 2'h0;
         bit_next = 4'h0;
         if (cmd_take) begin
            sh_next = AVS_WRITEDATA_I[7:0];
            nreq_next = AVS_WRITEDATA_I[`HTW_NACK_BIT];
            nack_next = 1'b0;
            rd_next = (op == HTW_OP_READ);
            case (op)
               HTW_OP_START: st_next = HS_START;
               HTW_OP_STOP: st_next = HS_STOP;
               default: st_next = HS_BYTE;
            endcase
         end
      end else if (tick) begin
         ph_next = ph_reg + 2'h1;
         case (st_reg)
            HS_START: begin
               case (ph_reg)
                  2'h0: sda_oe_next = 1'b0;
                  2'h1: scl_oe_next = 1'b0;
                  2'h2: sda_oe_next = 1'b1;
                  default: begin
                     scl_oe_next = 1'b1;
                     st_next = HS_IDLE;
                  end
               endcase
            end
            HS_STOP: begin
               case (ph_reg)
                  2'h0: sda_oe_next = 1'b1;
                  2'h1: scl_oe_next = 1'b0;
                  2'h2: sda_oe_next = 1'b0;
                  default: st_next = HS_IDLE;
               endcase
            end
            default: begin
               case (ph_reg)
                  2'h0: begin
                     sda_oe_next = ack_bit ? (rd_reg & !nreq_reg)
                                           : (!rd_reg & !sh_reg[7]);
                  end
                  2'h1: scl_oe_next = 1'b0;
                  2'h2: begin
                     if (ack_bit) begin
                        nack_next = !rd_reg & sda_s;
                     end else begin
                        sh_next = {sh_reg[6:0], sda_s};
                     end
                  end
                  default: begin
                     scl_oe_next = 1'b1;
                     bit_next = bit_reg + 4'h1;
                     if (ack_bit) begin
                        st_next = HS_IDLE;
                        rx_next = sh_reg;
                     end
                  end
               endcase
            end
         endcase
      end
   end
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         st_reg <= HS_IDLE;
         ph_reg <= 2'h0;
         qcnt_reg <= 8'h00;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         rx_reg <= 8'h00;
         rd_reg <= 1'b0;
         nreq_reg <= 1'b0;
         nack_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         ph_reg <= ph_next;
         qcnt_reg <= qcnt_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         rx_reg <= rx_next;
         rd_reg <= rd_next;
         nreq_reg <= nreq_next;
         nack_reg <= nack_next;
         scl_oe_reg <= scl_oe_next;
         sda_oe_reg <= sda_oe_next;
      end
   end
   assign AVS_READDATA_O = rdata_reg;
   assign AVS_WAITREQUEST_O = wait_reg;
   assign DEV_NRST_O = rst_done_reg;
   assign HBUS.host_scl_out = 1'b0;
   assign HBUS.host_scl_oe = scl_oe_reg;
   assign HBUS.host_sda_out = 1'b0;
   assign HBUS.host_sda_oe = sda_oe_reg;
endmodule

// ==== test/htwrp_asserts.sv ====
`timescale 1ns/1ns
`include "htwrp_defs.svh"
module htwrp_asserts #(
   parameter logic [6:0] ADDR = {`HTW_FIXED_ADDR, 2'h3}
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   logic scl_reg, sda_reg, sel_reg, rd_reg, first_reg;
   logic [3:0] cnt_reg;
   logic [6:0] sh_reg;
   logic [10:0] hold_reg;
   wire rise_w = scl & ~scl_reg;
   wire start_w = scl & scl_reg & sda_reg & ~sda;
   wire stop_w = scl & scl_reg & ~sda_reg & sda;
   wire ack_w = rise_w & (cnt_reg == 4'h8);
   wire bit_w = rise_w & (cnt_reg != 4'h8);
   // Wires come from registers in this domain, so no sync stage
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {scl_reg, sda_reg, sel_reg, rd_reg, first_reg} <= 5'h18;
         cnt_reg <= 4'h0;
         sh_reg <= 7'h00;
      end else begin
         scl_reg <= scl;
         sda_reg <= sda;
         if (start_w || stop_w) begin
            {cnt_reg, first_reg, sel_reg} <= {4'h0, start_w, 1'b0};
         end else if (bit_w) begin
            sh_reg <= {sh_reg[5:0], sda};
            cnt_reg <= cnt_reg + 4'h1;
            if (first_reg && cnt_reg == 4'h7) begin
               sel_reg <= (sh_reg == ADDR);
               rd_reg <= sda;
            end
         end else if (ack_w) begin
            cnt_reg <= 4'h0;
            first_reg <= 1'b0;
            if (!first_reg && rd_reg && sda) sel_reg <= 1'b0;
         end
      end
   end
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) hold_reg <= 11'h000;
      else hold_reg <= dev_sda_oe ? hold_reg + 11'h001 : 11'h000;
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   addr_ack_a: assert property (
      ack_w && first_reg && sel_reg |-> dev_sda_oe)
      else $error("own address not acknowledged");
   foreign_nack_a: assert property (
      ack_w && first_reg && !sel_reg |-> sda)
      else $error("foreign address acknowledged");
   quiet_unsel_a: assert property (
      !sel_reg |-> !dev_sda_oe)
      else $error("device drives data while not selected");
   write_ack_a: assert property (
      ack_w && !first_reg && sel_reg && !rd_reg |-> dev_sda_oe)
      else $error("written byte not acknowledged");
   host_ack_free_a: assert property (
      ack_w && !first_reg && rd_reg |-> !dev_sda_oe)
      else $error("data held during host acknowledge");
   rx_quiet_a: assert property (
      bit_w && (first_reg || !rd_reg) |-> !dev_sda_oe)
      else $error("device drives during received bits");
   high_stable_a: assert property (
      scl && scl_reg |-> $stable(dev_sda_oe))
      else $error("device data changed while clock high");
   hold_bound_a: assert property (
      hold_reg < 11'h514)
      else $error("device holds data line too long");
   cover property (ack_w && first_reg && sel_reg && rd_reg);
   cover property (ack_w && first_reg && sel_reg && !rd_reg);
   cover property (ack_w && first_reg && !sel_reg);
endmodule

// ==== test/host_two_wire_register_port_tb.sv ====
`timescale 1ns/1ns
`include "htwrp_defs.svh"
module host_two_wire_register_port_tb;
   import htwrp_pkg::*;
   localparam logic [6:0] ADDR = {`HTW_FIXED_ADDR, 2'h3};
   logic clk = 1'b0, nrst = 1'b0, tclk_low = 1'b0, tdata_low = 1'b0;
   logic avs_wr = 1'b0, avs_rd = 1'b0;
   logic [1:0] strap = 2'h3;
   logic [3:0] avs_addr = 4'h0;
   logic [31:0] avs_wdata = 32'h0, rdata, st;
   logic [31:0] lfsr = 32'h000173F8;
   logic wreq, host_nrst, gp0_o, gp0_oe, gp1_o, gp1_oe, reg_wr;
   htwrp_byte_t mem [256] = '{default: 8'h00};
   htwrp_byte_t wa, wd;
   int num_errors = 0, tests_run = 0, wr_cnt = 0;
   wire dev_nrst = nrst & host_nrst;
   wire gp0 = gp0_oe ? gp0_o : 1'b1;
   wire gp1 = gp1_oe ? gp1_o : 1'b1;
   htwrp_if hbus ();
   htwrp_host #(.RESET_HOLD_CYC(20)) i_htwrp_host (.CORE_CLK_I(clk),
      .NRST_I(nrst), .AVS_ADDRESS_I(avs_addr), .AVS_READ_I(avs_rd),
      .AVS_WRITE_I(avs_wr), .AVS_WRITEDATA_I(avs_wdata),
      .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(wreq), .DEV_NRST_O(host_nrst), .HBUS(hbus));
   htwrp_device i_htwrp_device (.CORE_CLK_I(clk), .NRST_I(dev_nrst),
      .BUS_ADDRESS_STRAP_I(strap), .TUNER_BUS_CLOCK_LOW_I(tclk_low),
      .TUNER_BUS_DATA_LOW_I(tdata_low), .GENERAL_PORT_BIT_ZERO_I(gp0),
      .GENERAL_PORT_BIT_ZERO_O(gp0_o), .GENERAL_PORT_BIT_ZERO_OE_O(gp0_oe),
      .GENERAL_PORT_BIT_ONE_I(gp1), .GENERAL_PORT_BIT_ONE_O(gp1_o),
      .GENERAL_PORT_BIT_ONE_OE_O(gp1_oe), .REG_WRITE_O(reg_wr),
      .REG_WRITE_ADDR_O(wa), .REG_WRITE_DATA_O(wd), .HBUS(hbus));
   htwrp_asserts i_htwrp_asserts (.core_clk_i(clk), .nrst_i(dev_nrst),
      .dev_sda_oe(hbus.dev_sda_oe), .scl(hbus.scl), .sda(hbus.sda));
   always #10 clk = ~clk;
   always @(posedge clk) if (reg_wr === 1'b1) wr_cnt++;
   task chk_byte(input htwrp_byte_t g, input htwrp_byte_t e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %0t byte %h exp %h", $time, g, e);
      end
   endtask
   task chk_bit(input logic g, input logic e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %0t bit %b exp %b", $time, g, e);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task rnd(output htwrp_byte_t b);
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      b = lfsr[7:0];
   endtask
   // Held until waitrequest is seen low at a rising edge
   task av(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      {avs_addr, avs_wdata, avs_wr, avs_rd} <= {a, d, w, !w};
      do @(posedge clk); while (wreq !== 1'b0);
      st = rdata;
      {avs_wr, avs_rd} <= 2'h0;
   endtask
   task op(input htwrp_op_e o, input htwrp_byte_t b, input logic nk);
      av(1'b1, `HTW_CMD_OFS, {21'h0, nk, o, b});
      do av(1'b0, `HTW_STAT_OFS, 32'h0); while (st[0] !== 1'b0);
   endtask
   task sa(input logic [6:0] a, input logic r);
      op(HTW_OP_START, 8'h00, 1'b0);
      op(HTW_OP_WRITE, {a, r}, 1'b0);
   endtask
   task rb(input logic nk, output htwrp_byte_t b);
      op(HTW_OP_READ, 8'h00, nk);
      av(1'b0, `HTW_RX_OFS, 32'h0);
      b = st[7:0];
   endtask
   task wr_burst(htwrp_byte_t p, int n, logic ren, htwrp_byte_t fd);
      htwrp_byte_t d;
      sa(ADDR, 1'b0);
      chk_bit(st[1], 1'b0);
      op(HTW_OP_WRITE, p, 1'b0);
      for (int i = 0; i < n; i++) begin
         if (ren) rnd(d);
         else d = fd;
         op(HTW_OP_WRITE, d, 1'b0);
         chk_byte(wa, p);
         chk_byte(wd, d);
         mem[p] = d;
         p++;
      end
      op(HTW_OP_STOP, 8'h00, 1'b0);
   endtask
   // Leaves the bus open after the last byte
   task rd_chk(input htwrp_byte_t p, input int n);
      htwrp_byte_t d;
      sa(ADDR, 1'b0);
      op(HTW_OP_WRITE, p, 1'b0);
      sa(ADDR, 1'b1);
      for (int i = 0; i < n; i++) begin
         rb(i == n - 1, d);
         chk_byte(d, mem[p]);
         p++;
      end
   endtask
   // ----------------
   // Tests
   // ----------------
   initial begin
      htwrp_byte_t p, d;
      int n;
      logic [6:0] bad [4] = '{7'h0C, 7'h0E, 7'h1F, 7'h4F};
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      wait (host_nrst === 1'b1);
      repeat (8) @(posedge clk);
      strap <= 2'h0;
      rnd(p);
      // Random bursts stay clear of port registers
      p = {2'h0, p[5:0]};
      wr_burst(8'hFE, 4, 1'b1, 8'h00);
      wr_burst(p, 3, 1'b1, 8'h00);
      sa(ADDR, 1'b1);
      for (int i = 0; i < 3; i++) begin
         rb(i == 2, d);
         chk_byte(d, mem[i]);
      end
      op(HTW_OP_STOP, 8'h00, 1'b0);
      $display("test write_read done");
      rd_chk(p, 2);
      sa(ADDR, 1'b0);
      rnd(d);
      op(HTW_OP_WRITE, d, 1'b0);
      mem[p + 8'h02] = d;
      op(HTW_OP_STOP, 8'h00, 1'b0);
      rd_chk(p + 8'h02, 1);
      op(HTW_OP_STOP, 8'h00, 1'b0);
      $display("test combined done");
      foreach (bad[i]) begin
         sa(bad[i], 1'b0);
         chk_bit(st[1], 1'b1);
         n = wr_cnt;
         op(HTW_OP_WRITE, 8'h11, 1'b0);
         op(HTW_OP_STOP, 8'h00, 1'b0);
         chk_bit(wr_cnt == n, 1'b1);
      end
      $display("test foreign done");
      wr_burst(8'h8C, 1, 1'b0, 8'h01);
      wr_burst(8'h62, 1, 1'b0, 8'h08);
      for (int i = 0; i < 4; i++) begin
         {tdata_low, tclk_low} <= i[1:0];
         repeat (3) @(posedge clk);
         chk_bit(gp0, !i[0]);
         chk_bit(gp1, !i[1]);
      end
      wr_burst(8'h62, 1, 1'b0, 8'h00);
      chk_bit(gp0 & gp1, 1'b1);
      wr_burst(8'h8C, 1, 1'b0, 8'h26);
      chk_bit(gp0, 1'b1);
      chk_bit(gp1, 1'b0);
      mem[8'h8D] = 8'h01;
      rd_chk(8'h8C, 2);
      op(HTW_OP_STOP, 8'h00, 1'b0);
      $display("test tuner done");
      give_verdict();
   end
   initial begin
      #1800000;
      num_errors++;
      $display("CHECK FAILED %0t timeout", $time);
      give_verdict();
   end
endmodule
